/* File: core/ssadc_pkg.sv */
// Purpose: Constants for the single-slope converter timer block.
// Assumes: 100 MHz system clock, registers reached over a plain port.
// Notes: Register offsets are byte addresses of 32-bit words.
// Functional notes
// - Four channels convert together; fourth channel goes through a 4-way selector.
// - Selector bits 1:0 pick aux input 0, 1, 2, or the reference.
// - A shared 12-bit timer measures start-to-crossing; counts stored per channel.
// - Each sync pulse discharges the ramp and restarts the timer.
// - Sync pulse width comes from a programmable register, 0.05 to 12.5 us.
// - Ramp current adjustable in eight steps over about twenty percent.
// - Mode bit 7 clear counts at half the input clock rate; set counts at clock rate, twice as fast.
// - On comparator trip each channel latches the shared timer value; the next sync copies it into its result register.
// - The count never exceeds 4095; it saturates there.
// - In double update mode sync comes twice per PWM period.
// - A channel not crossing before the next sync reads zero.
// - Trim is 3 bits; 0 is minimum current, 7 is maximum.
// - Trim resets to zero.
// - Fault shutdown suppresses the sync pulse so no conversion starts.
package ssadc_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int CNT_W = 12;
	localparam int NCH = 4;
	localparam logic [ADDR_W-1:0] OFF_MODE = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_SYNCW = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_TRIM = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hC;
	localparam logic [ADDR_W-1:0] OFF_RES_BASE = 4'h0;
	localparam int SEL_LSB = 0;
	localparam int RATE_BIT = 7;
	localparam int MODE_W = 8;
	localparam int SYNCW_W = 11;
	localparam int TRIM_W = 3;
	localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
	localparam logic [TRIM_W-1:0] TRIM_RST = 3'h0;
	localparam logic [CNT_W-1:0] CNT_MAX = 12'hFFF;
	localparam logic [CNT_W-1:0] RES_NONE = 12'h000;
	localparam real SYNCW_MIN_NS = 50.0;
	localparam real SYNCW_MAX_NS = 12500.0;
	localparam real CLK_NS = 10.0;
	localparam int SYNCW_MIN_CYC = int'($ceil(SYNCW_MIN_NS / CLK_NS));
	localparam int SYNCW_MAX_CYC = int'($floor(SYNCW_MAX_NS / CLK_NS));
	localparam logic [1:0] SEL_REF = 2'h3;
endpackage

/* File: core/ssadc_top.sv */
// Purpose: Digital side of a four-channel single-slope converter.
// Assumes: Comparator and sync inputs synchronous to I_SYS_CLK.
// Notes: Results live at word addresses 0x10..0x1C (bank bit 4).
`timescale 1ns/10ps
`default_nettype none
module ssadc_top #(
	parameter int CNT_W = ssadc_pkg::CNT_W
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RSTN,
	input wire logic [4:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_SYNC_REQ,
	input wire logic I_FAULT_N,
	input wire logic [2:0] I_CMP_MAIN,
	input wire logic I_CMP_AUX,
	output logic [31:0] O_RDATA,
	output logic O_RAMP_RESET,
	output logic [1:0] O_AUX_SEL,
	output logic [2:0] O_RAMP_TRIM
);
	// ********************************
	// Reset release
	// ********************************
	logic rst_s1_q;
	logic rst_n_q;
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// ********************************
	// Register decode
	// ********************************
	logic [ssadc_pkg::MODE_W-1:0] mode_q;
	logic [ssadc_pkg::SYNCW_W-1:0] syncw_q;
	logic [ssadc_pkg::TRIM_W-1:0] trim_q;
	wire bank_res = I_ADDR[4];
	wire [3:0] low_addr = I_ADDR[3:0];
	wire wr_mode = I_WR && !bank_res && low_addr == ssadc_pkg::OFF_MODE;
	wire wr_syncw = I_WR && !bank_res && low_addr == ssadc_pkg::OFF_SYNCW;
	wire wr_trim = I_WR && !bank_res && low_addr == ssadc_pkg::OFF_TRIM;
	wire fast_rate = mode_q[ssadc_pkg::RATE_BIT];
	// Out-of-range width values are clamped so the ramp always gets
	// a full discharge and the conversion window is never swallowed
	wire [ssadc_pkg::SYNCW_W-1:0] syncw_lo =
		ssadc_pkg::SYNCW_W'(ssadc_pkg::SYNCW_MIN_CYC);
	wire [ssadc_pkg::SYNCW_W-1:0] syncw_hi =
		ssadc_pkg::SYNCW_W'(ssadc_pkg::SYNCW_MAX_CYC);
	wire [ssadc_pkg::SYNCW_W-1:0] syncw_eff =
		(syncw_q < syncw_lo) ? syncw_lo :
		(syncw_q > syncw_hi) ? syncw_hi : syncw_q;

	always_ff @(posedge I_SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mode_q <= ssadc_pkg::MODE_RST;
			syncw_q <= '0;
			trim_q <= ssadc_pkg::TRIM_RST;
		end else begin
			if (wr_mode)
				mode_q <= I_WDATA[ssadc_pkg::MODE_W-1:0];
			if (wr_syncw)
				syncw_q <= I_WDATA[ssadc_pkg::SYNCW_W-1:0];
			if (wr_trim)
				trim_q <= I_WDATA[ssadc_pkg::TRIM_W-1:0];
		end
	end

	// ********************************
	// Sync pulse and ramp reset
	// ********************************
	logic sync_q;
	logic [ssadc_pkg::SYNCW_W-1:0] wcnt_q;
	logic ramp_rst_q;
	// Double update mode simply means the generator fires twice per period;
	// every qualifying edge restarts a conversion
	wire sync_rise = I_SYNC_REQ && !sync_q && I_FAULT_N;
	always_ff @(posedge I_SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync_q <= 1'b0;
			wcnt_q <= '0;
			ramp_rst_q <= 1'b0;
		end else begin
			sync_q <= I_SYNC_REQ;
			if (sync_rise) begin
				wcnt_q <= syncw_eff;
				ramp_rst_q <= 1'b1;
			end else if (wcnt_q > 1) begin
				wcnt_q <= wcnt_q - 1'b1;
			end else begin
				wcnt_q <= '0;
				ramp_rst_q <= 1'b0;
			end
		end
	end
	// Conversion starts when the discharge window closes
	wire conv_start = ramp_rst_q && wcnt_q <= 1 && !sync_rise;

	// ********************************
	// Shared timer
	// ********************************
	logic [CNT_W-1:0] tmr_q;
	logic div_q;
	logic run_q;
	wire tick = fast_rate || div_q;
	wire at_max = tmr_q == CNT_W'(ssadc_pkg::CNT_MAX);
	always_ff @(posedge I_SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			tmr_q <= '0;
			div_q <= 1'b0;
			run_q <= 1'b0;
		end else begin
			div_q <= conv_start ? 1'b0 : !div_q;
			if (sync_rise) begin
				tmr_q <= '0;
				run_q <= 1'b0;
			end else if (conv_start) begin
				tmr_q <= '0;
				run_q <= 1'b1;
			end else if (run_q && tick && !at_max) begin
				tmr_q <= tmr_q + 1'b1;
			end
		end
	end

	// ********************************
	// Channel capture
	// ********************************
	wire [ssadc_pkg::NCH-1:0] cmp = {I_CMP_AUX, I_CMP_MAIN};
	logic [CNT_W-1:0] res_q [ssadc_pkg::NCH];
	logic [CNT_W-1:0] acc_q [ssadc_pkg::NCH];
	logic [ssadc_pkg::NCH-1:0] done_q;
	genvar g;
	generate
		for (g = 0; g < ssadc_pkg::NCH; g++) begin : g_ch
			always_ff @(posedge I_SYS_CLK or negedge rst_n_q) begin
				if (!rst_n_q) begin
					acc_q[g] <= ssadc_pkg::RES_NONE;
					res_q[g] <= ssadc_pkg::RES_NONE;
					done_q[g] <= 1'b0;
				end else if (sync_rise) begin
					// Missed crossings publish zero
					res_q[g] <= done_q[g] ? acc_q[g]
						: ssadc_pkg::RES_NONE;
					acc_q[g] <= ssadc_pkg::RES_NONE;
					done_q[g] <= 1'b0;
				end else if (run_q && cmp[g] && !done_q[g]) begin
					acc_q[g] <= tmr_q;
					done_q[g] <= 1'b1;
				end
			end
		end
	endgenerate

	// ********************************
	// Read port
	// ********************************
	wire [1:0] ridx = low_addr[3:2];
	wire [31:0] rd_cfg =
		(low_addr == ssadc_pkg::OFF_MODE) ? 32'(mode_q) :
		(low_addr == ssadc_pkg::OFF_SYNCW) ? 32'(syncw_q) :
		(low_addr == ssadc_pkg::OFF_TRIM) ? 32'(trim_q) :
		(low_addr == ssadc_pkg::OFF_STATUS) ?
			32'({run_q, done_q}) : 32'h00000000;
	wire [31:0] rd_mux = bank_res ? 32'(res_q[ridx]) : rd_cfg;
	always_ff @(posedge I_SYS_CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			O_RDATA <= 32'h00000000;
			O_RAMP_RESET <= 1'b1;
			O_AUX_SEL <= 2'h0;
			O_RAMP_TRIM <= ssadc_pkg::TRIM_RST;
		end else begin
			O_RDATA <= I_RD ? rd_mux : 32'h00000000;
			O_RAMP_RESET <= ramp_rst_q || !I_FAULT_N;
			O_AUX_SEL <= mode_q[ssadc_pkg::SEL_LSB+:2];
			O_RAMP_TRIM <= trim_q;
		end
	end
endmodule // ssadc_top
`default_nettype wire

/* File: sim/ssadc_props.sv */
// Purpose: Port checks for the converter timer block.
// Assumes: Bound to ssadc_top.
// Notes: Sync, ramp reset and register relations.
`timescale 1ns/10ps
`default_nettype none
module ssadc_props #(parameter int CNT_W = 12) (
	input wire logic I_SYS_CLK,
	input wire logic I_RSTN,
	input wire logic [4:0] I_ADDR,
	input wire logic [31:0] I_WDATA,
	input wire logic I_WR,
	input wire logic I_RD,
	input wire logic I_SYNC_REQ,
	input wire logic I_FAULT_N,
	input wire logic [31:0] O_RDATA,
	input wire logic O_RAMP_RESET,
	input wire logic [1:0] O_AUX_SEL,
	input wire logic [2:0] O_RAMP_TRIM
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RSTN);
	logic [10:0] hi_q;
	// Fault time is left out: the clamp only bounds sync-driven pulses
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
		if (!I_RSTN) hi_q <= 11'h0;
		else hi_q <= (O_RAMP_RESET && I_FAULT_N) ? hi_q + 11'h1 : 11'h0;
	sequence s_start; $rose(I_SYNC_REQ) && I_FAULT_N; endsequence
	sequence s_clamp; O_RAMP_RESET [*5]; endsequence
	AST_SYNC_RAMP: assert property (s_start |-> ##[1:2] s_clamp)
		else $error("sync did not reset the ramp");
	AST_WIDTH_MIN: assert property ($rose(O_RAMP_RESET) && I_FAULT_N |->
		s_clamp) else $error("ramp reset too short");
	AST_WIDTH_MAX: assert property (hi_q <= 11'h4E4)
		else $error("ramp reset too long");
	AST_FAULT_HOLD: assert property (!I_FAULT_N |-> ##1 O_RAMP_RESET)
		else $error("ramp released during fault");
	AST_SEL_WRITE: assert property (I_WR && I_ADDR == 5'h00 |->
		##2 O_AUX_SEL == $past(I_WDATA[1:0], 2)) else $error("sel");
	AST_TRIM_WRITE: assert property (I_WR && I_ADDR == 5'h08 |->
		##2 O_RAMP_TRIM == $past(I_WDATA[2:0], 2)) else $error("trim");
	AST_TRIM_READ: assert property (I_RD && I_ADDR == 5'h08 |=>
		O_RDATA == {29'h0, O_RAMP_TRIM}) else $error("trim read");
	AST_RES_WIDTH: assert property (I_RD && I_ADDR[4] |=>
		(O_RDATA >> CNT_W) == 32'h0) else $error("result width");
endmodule // ssadc_props
bind ssadc_top ssadc_props #(.CNT_W(CNT_W)) u_props (.I_SYS_CLK(I_SYS_CLK),
	.I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
	.I_RD(I_RD), .I_SYNC_REQ(I_SYNC_REQ), .I_FAULT_N(I_FAULT_N),
	.O_RDATA(O_RDATA), .O_RAMP_RESET(O_RAMP_RESET), .O_AUX_SEL(O_AUX_SEL),
	.O_RAMP_TRIM(O_RAMP_TRIM));
`default_nettype wire

/* File: sim/ssadc_ramp_model.sv */
// Purpose: Ramp capacitor and comparators seen by the block.
// Assumes: Ramp rises one step per clock once released.
// Notes: th holds a, b, c, aux0, aux1, aux2, reference.
`timescale 1ns/10ps
`default_nettype none
module ssadc_ramp_model (
	input wire logic clk,
	input wire logic ramp_rst,
	input wire logic [1:0] sel,
	input wire logic [6:0][15:0] th,
	output logic [2:0] cmp_main,
	output logic cmp_aux
);
	logic [15:0] ramp_q;
	always_ff @(posedge clk) ramp_q <= ramp_rst ? 16'h0 : ramp_q + 16'h1;
	always_comb begin
		for (int i = 0; i < 3; i++) cmp_main[i] = !ramp_rst && ramp_q >= th[i];
		cmp_aux = !ramp_rst && ramp_q >= th[3 + sel];
	end
endmodule // ssadc_ramp_model
`default_nettype wire

/* File: sim/ssadc_top_test.sv */
// Purpose: Self-checking bench for the converter timer block.
// Assumes: Ramp model feeds all four comparators.
// Notes: Results are read one sync after their conversion.
`timescale 1ns/10ps
`default_nettype none
module ssadc_top_test;
	logic clk = 0, rstn = 0, wr = 0, rd = 0, sync = 0, fault_n = 1;
	logic [4:0] addr = 5'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic ramp_rst, cmp_a;
	logic [1:0] sel;
	logic [2:0] trim, cmp_m;
	logic [6:0][15:0] th = {16'h01C2, 16'h015E, 16'h00FA, 16'h0096,
		16'h02BC, 16'h012C, 16'h0064};
	logic [11:0] r [4];
	int n_errors = 0, samples_checked = 0, hi = 0, last_w = 0;
	initial forever #5 clk = ~clk;
	ssadc_top DUT (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr),
		.I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_SYNC_REQ(sync),
		.I_FAULT_N(fault_n), .I_CMP_MAIN(cmp_m), .I_CMP_AUX(cmp_a),
		.O_RDATA(rdata), .O_RAMP_RESET(ramp_rst), .O_AUX_SEL(sel),
		.O_RAMP_TRIM(trim));
	ssadc_ramp_model u_ramp (.clk(clk), .ramp_rst(ramp_rst), .sel(sel),
		.th(th), .cmp_main(cmp_m), .cmp_aux(cmp_a));
	always @(posedge clk) begin
		if (ramp_rst) hi <= hi + 1;
		else if (hi > 0) begin last_w <= hi; hi <= 0; end
	end
	task complete_run;
		if (n_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [4:0] a, input logic [31:0] v);
		@(posedge clk); wr <= 1; addr <= a; wdata <= v;
		@(posedge clk); wr <= 0;
	endtask
	task rd_reg(input logic [4:0] a);
		@(posedge clk); rd <= 1; addr <= a;
		@(posedge clk); rd <= 0;
		#1 d = rdata;
	endtask
	// Second sync publishes the first conversion, then results are read
	task conv2(input int n);
		for (int j = 0; j < 2; j++) begin
			@(posedge clk); sync <= 1;
			repeat (n) @(posedge clk);
			sync <= 0;
		end
		for (int i = 0; i < 4; i++) begin
			rd_reg(5'h10 + 5'(4 * i)); r[i] = d[11:0];
		end
	endtask
	initial begin
		repeat (40000) @(posedge clk);
		n_errors++;
		complete_run;
	end
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1;
		repeat (3) @(posedge clk);
		rd_reg(5'h08); chk(d, 32'h0);
		wr_reg(5'h08, 32'h7); rd_reg(5'h08); chk(d, 32'h7);
		chk(trim, 3'h7);
		wr_reg(5'h04, 32'h14);
		for (int k = 0; k < 4; k++) begin
			wr_reg(5'h00, 32'h80 | k); conv2(1000);
			chk(sel, k);
			chk(last_w, 20);
			chk(r[1] - r[0], 32'hC8);
			chk(r[2] - r[0], 32'h258);
			chk(r[3] - r[0], th[3 + k] - 16'h0064);
		end
		wr_reg(5'h08, 32'h0); rd_reg(5'h08); chk(trim, 3'h0);
		wr_reg(5'h00, 32'h0); conv2(1000);
		chk((r[1] - r[0]) inside {[99:101]}, 1);
		th[2] = 16'h1388; th[3] = 16'hFFFF;
		wr_reg(5'h00, 32'h80); wr_reg(5'h04, 32'h2); conv2(5200);
		chk(r[2], 12'hFFF);
		chk(r[3], 12'h000);
		chk(last_w, 5);
		@(posedge clk); fault_n <= 0; conv2(50);
		chk(ramp_rst, 1);
		chk(r[2], 12'hFFF);
		chk(r[3], 12'h000);
		complete_run;
	end
endmodule // ssadc_top_test
`default_nettype wire
